/* pcr_defs.svh */
// Constants for the pad control and register block map.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH

`define PCR_OFF_PULL        9'h00C
`define PCR_OFF_DRIVE       9'h00D
`define PCR_OFF_BASE        9'h011

`define PCR_MASK_PULL       8'hD3
`define PCR_MASK_DRIVE      8'h6B
`define PCR_MASK_BASE       8'hF9

`define PCR_RST_PULL        8'hD0
`define PCR_RST_DRIVE       8'h00
`define PCR_RST_BASE        8'h00

`define PCR_PU_H            7
`define PCR_PU_G            6
`define PCR_PU_E            4
`define PCR_PU_B            1
`define PCR_PU_A            0

`define PCR_LD_H            6
`define PCR_LD_G            5
`define PCR_LD_E            3
`define PCR_LD_B            1
`define PCR_LD_A            0

`define PCR_BASE_HI         7
`define PCR_BASE_LO         3
`define PCR_STOP_BIT        0

`define PCR_ADDR_BLK_HI     15
`define PCR_ADDR_BLK_LO     11
`define PCR_ADDR_WIN_HI     10
`define PCR_ADDR_WIN_LO     9
`define PCR_ADDR_OFF_HI     8

`define PCR_E_PULL_PINS     8'h8F
`define PCR_WIN_LOW         2'h0
`define PCR_SEL_RESET       1'h0
`define PCR_SYNC_RESET      3'h0
`define PCR_RDATA_IDLE      8'h00
`define PCR_DIR_UP          1'b1
`define PCR_DIR_DOWN        1'b0

`endif

/* pcr_pkg.sv */
// Types shared by the pad control block and its surroundings.
// Assumes pcr_defs.svh is on the include path.
`include "pcr_defs.svh"

package pcr_pkg;

  typedef struct packed {
    logic [7:0] h;
    logic [7:0] g;
    logic [7:0] e;
    logic [7:0] b;
    logic [7:0] a;
  } pcr_dir_t;

  typedef struct packed {
    logic [7:0] pull_en;
    logic       pull_up;
    logic       low_drive;
  } pcr_pad_t;

endpackage : pcr_pkg

/* pcr_pad_regs.sv */
// Pad pull and drive control registers plus the relocatable register block decoder.
// Assumes a CPU bus on i_sys_clk, port direction bits from the port logic on the same clock,
// and the two pull-select pins arriving asynchronously from the package.
// The pad outputs feed the pad ring directly; the port logic applies them to the pins.
//
// Function
// RL1 - Software moves the register block to any 2K boundary via base bits.
// RL2 - Block is selected only when address bits 15 to 11 equal base bits.
// RL3 - Only the lowest 512 bytes of the 2K window belong to the block.
// RL4 - After reset the base is zero, so address zero starts the map.
// RL5 - One software pull enable bit per port group in the pull register.
// RL6 - One reduced drive bit per port group; cleared means full drive.
// RL7 - Enabled port G pulls go up when its select pin is high, else down.
// RL8 - Enabled port H pulls go up when its select pin is high, else down.
// RL9 - Small package holds the port G select high internally.
// RL10 - Small package holds the port H select low internally.
// RL11 - A pin programmed as output never gets its pull, whatever the enable; the registered pad drops it one cycle after the direction change.
// RL12 - Reset enables E, G, H pulls, disables A, B, clears all drive bits.
// RL13 - Pull bits H,G,E,B,A at 7,6,4,1,0; drive bits at 6,5,3,1,0.
`include "pcr_defs.svh"

module pcr_pad_regs
  import pcr_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_block_hit,
  input  wire logic       i_port_g_pull_select_pin,
  input  wire logic       i_port_h_pull_select_pin,
  input  wire pcr_dir_t   i_dir,
  output pcr_pad_t        o_pad_a,
  output pcr_pad_t        o_pad_b,
  output pcr_pad_t        o_pad_e,
  output pcr_pad_t        o_pad_g,
  output pcr_pad_t        o_pad_h,
  output logic      [4:0] o_register_block_base,
  output logic            o_map_stop_in_wait
);

  logic [7:0] pull_enable_control;
  logic [7:0] drive_strength_control;
  logic [7:0] register_block_base;
  logic [8:0] offset;
  logic       blk_match;
  logic       win_low;
  logic       wr_pull;
  logic       wr_drive;
  logic       wr_base;
  logic       rd_hit;
  logic [7:0] next_rdata;
  logic [2:0] g_sync;
  logic [2:0] h_sync;
  logic       g_level;
  logic       h_level;
  logic       g_up;
  logic       h_up;
  pcr_pad_t   next_pad_a;
  pcr_pad_t   next_pad_b;
  pcr_pad_t   next_pad_e;
  pcr_pad_t   next_pad_g;
  pcr_pad_t   next_pad_h;

  // The decode is combinational so a strobe is taken in its own cycle, never stalled.
  assign offset      = i_addr[`PCR_ADDR_OFF_HI:0];
  assign blk_match   = (i_addr[`PCR_ADDR_BLK_HI:`PCR_ADDR_BLK_LO] ==
                        register_block_base[`PCR_BASE_HI:`PCR_BASE_LO]); // see RL2
  assign win_low     = (i_addr[`PCR_ADDR_WIN_HI:`PCR_ADDR_WIN_LO] == `PCR_WIN_LOW); // see RL3
  assign o_block_hit = blk_match && win_low;

  assign o_register_block_base = register_block_base[`PCR_BASE_HI:`PCR_BASE_LO];
  assign o_map_stop_in_wait    = register_block_base[`PCR_STOP_BIT];

  // Offsets other than the three registers match no strobe, so their writes are lost.
  assign wr_pull  = i_wr && o_block_hit && (offset == `PCR_OFF_PULL);
  assign wr_drive = i_wr && o_block_hit && (offset == `PCR_OFF_DRIVE);
  assign wr_base  = i_wr && o_block_hit && (offset == `PCR_OFF_BASE);
  assign rd_hit   = i_rd && o_block_hit;

  // Unimplemented bits are masked on write so they always read back as zero.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      pull_enable_control <= `PCR_RST_PULL; // see RL12
    end else if (wr_pull) begin
      pull_enable_control <= i_wdata & `PCR_MASK_PULL; // see RL5
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      drive_strength_control <= `PCR_RST_DRIVE; // see RL12
    end else if (wr_drive) begin
      drive_strength_control <= i_wdata & `PCR_MASK_DRIVE; // see RL6
    end
  end

  // A write to the base takes effect at once; the next access must use the new window.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      register_block_base <= `PCR_RST_BASE; // see RL4
    end else if (wr_base) begin
      register_block_base <= i_wdata & `PCR_MASK_BASE; // see RL1
    end
  end

  always_comb begin
    if (!rd_hit) begin
      next_rdata = `PCR_RDATA_IDLE;
    end else if (offset == `PCR_OFF_PULL) begin
      next_rdata = pull_enable_control;
    end else if (offset == `PCR_OFF_DRIVE) begin
      next_rdata = drive_strength_control;
    end else if (offset == `PCR_OFF_BASE) begin
      next_rdata = register_block_base;
    end else begin
      next_rdata = `PCR_RDATA_IDLE;
    end
  end

  // Read data stand for the one cycle after the strobe and are zero otherwise.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_rdata <= `PCR_RDATA_IDLE;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // Only the first stage may go metastable; nothing but the second stage reads it.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      g_sync <= `PCR_SYNC_RESET;
    end else begin
      g_sync <= {g_sync[1:0], i_port_g_pull_select_pin};
    end
  end

  // A level is accepted only once two later stages agree, which rejects single glitches.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      g_level <= `PCR_SEL_RESET;
    end else if (g_sync[2] == g_sync[1]) begin
      g_level <= g_sync[1];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      h_sync <= `PCR_SYNC_RESET;
    end else begin
      h_sync <= {h_sync[1:0], i_port_h_pull_select_pin};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      h_level <= `PCR_SEL_RESET;
    end else if (h_sync[2] == h_sync[1]) begin
      h_level <= h_sync[1];
    end
  end

  // The small package ties both select inputs inside, so the pin levels are ignored there.
  always_comb begin
    if (SMALL_PACKAGE) begin
      g_up = `PCR_DIR_UP; // see RL9
    end else begin
      g_up = g_level; // see RL7
    end
  end

  always_comb begin
    if (SMALL_PACKAGE) begin
      h_up = `PCR_DIR_DOWN; // see RL10
    end else begin
      h_up = h_level; // see RL8
    end
  end

  // A pin driven as an output loses its pull at the pad one cycle after the direction change, whatever the enable says.
  always_comb begin
    next_pad_a           = '0;
    next_pad_a.pull_en   = {8{pull_enable_control[`PCR_PU_A]}} & ~i_dir.a; // see RL11
    next_pad_a.pull_up   = `PCR_DIR_UP;
    next_pad_a.low_drive = drive_strength_control[`PCR_LD_A]; // see RL13
  end

  always_comb begin
    next_pad_b           = '0;
    next_pad_b.pull_en   = {8{pull_enable_control[`PCR_PU_B]}} & ~i_dir.b; // see RL11
    next_pad_b.pull_up   = `PCR_DIR_UP;
    next_pad_b.low_drive = drive_strength_control[`PCR_LD_B]; // see RL13
  end

  // Three port E pins have no pull device at all, so their enables stay low.
  always_comb begin
    next_pad_e           = '0;
    next_pad_e.pull_en   = {8{pull_enable_control[`PCR_PU_E]}} & ~i_dir.e &
                           `PCR_E_PULL_PINS; // see RL11
    next_pad_e.pull_up   = `PCR_DIR_UP;
    next_pad_e.low_drive = drive_strength_control[`PCR_LD_E]; // see RL13
  end

  always_comb begin
    next_pad_g           = '0;
    next_pad_g.pull_en   = {8{pull_enable_control[`PCR_PU_G]}} & ~i_dir.g; // see RL11
    next_pad_g.pull_up   = g_up; // see RL7
    next_pad_g.low_drive = drive_strength_control[`PCR_LD_G]; // see RL13
  end

  always_comb begin
    next_pad_h           = '0;
    next_pad_h.pull_en   = {8{pull_enable_control[`PCR_PU_H]}} & ~i_dir.h; // see RL11
    next_pad_h.pull_up   = h_up; // see RL8
    next_pad_h.low_drive = drive_strength_control[`PCR_LD_H]; // see RL13
  end

  // Pad controls are registered so the pads never see decode glitches.
  // The cost is one cycle of delay after a register write or a direction change.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_pad_a <= '0;
    end else begin
      o_pad_a <= next_pad_a;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_pad_b <= '0;
    end else begin
      o_pad_b <= next_pad_b;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_pad_e <= '0;
    end else begin
      o_pad_e <= next_pad_e;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_pad_g <= '0;
    end else begin
      o_pad_g <= next_pad_g;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_pad_h <= '0;
    end else begin
      o_pad_h <= next_pad_h;
    end
  end

endmodule : pcr_pad_regs

/* pcr_pad_regs_monitor.sv */
// Checker bound to the pad control block ports.
// Assumes one clock domain and a synchronous active-high reset.
module pcr_pad_regs_monitor
  import pcr_pkg::*;
#(parameter bit SMALL_PACKAGE = 1'b0) (
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic [15:0] i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_block_hit,
  input wire logic        i_port_g_pull_select_pin,
  input wire logic        i_port_h_pull_select_pin,
  input wire pcr_dir_t    i_dir,
  input wire pcr_pad_t    o_pad_a,
  input wire pcr_pad_t    o_pad_g,
  input wire pcr_pad_t    o_pad_h,
  input wire logic [4:0]  o_register_block_base,
  input wire logic        o_map_stop_in_wait
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  logic [7:0] dir_g;
  assign dir_g = i_dir.g;
  a_hit_decode: assert property (o_block_hit == (i_addr[15:11] == o_register_block_base
    && i_addr[10:9] == 2'h0)) else $error("hit decode");
  a_miss_read: assert property (i_rd && !o_block_hit |=> o_rdata == 8'h00)
    else $error("miss read");
  a_base_write: assert property (i_wr && o_block_hit && i_addr[8:0] == 9'h011 |=>
    {o_register_block_base, 2'h0, o_map_stop_in_wait} == ($past(i_wdata) & 8'hF9))
    else $error("base write");
  a_base_reset: assert property ($fell(i_reset) |-> o_register_block_base == 5'h00)
    else $error("base reset");
  a_drive_low: assert property (i_wr && o_block_hit && i_addr[8:0] == 9'h00D |-> ##2
    o_pad_a.low_drive == $past(i_wdata[0], 2)) else $error("drive");
  a_out_nopull: assert property ((o_pad_g.pull_en & $past(dir_g)) == 8'h00)
    else $error("pull on output");
  // Six samples cover the three-stage synchronizer, the level register and the pad register.
  a_g_select: assert property (i_port_g_pull_select_pin [*6] |-> o_pad_g.pull_up)
    else $error("g select");
  a_h_select: assert property (!i_port_h_pull_select_pin [*6] |-> !o_pad_h.pull_up)
    else $error("h select");
  c_move: cover property (i_wr && o_block_hit && i_addr[8:0] == 9'h011);
  c_miss: cover property (i_rd && !o_block_hit);
  c_g_up: cover property (o_pad_g.pull_up);
endmodule : pcr_pad_regs_monitor
bind pcr_pad_regs pcr_pad_regs_monitor #(.SMALL_PACKAGE(SMALL_PACKAGE)) pcr_pad_regs_monitor_i (.*);

/* tb.sv */
// Self-checking bench for the pad control and register block map.
// Assumes the package, design and checker are compiled before it.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              rd_q = 1'b0;
  logic              pg = 1'b0;
  logic              ph = 1'b1;
  logic [15:0]       addr = 16'h0000;
  logic [7:0]        wdata = 8'h00;
  logic [7:0]        rdata;
  logic [7:0]        v;
  logic [39:0]       dir = 40'h0;
  pcr_pkg::pcr_pad_t pa, pb, pe, pgo, pho, pgs, phs;
  logic              hit;
  logic [4:0]        base;
  logic              stop;
  logic [7:0]        expq[$];
  int                n_mismatch = 0;
  int                total_checks = 0;
  always #5 clk = ~clk;
  pcr_pad_regs pcr_pad_regs_i (.i_sys_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_block_hit(hit), .i_port_g_pull_select_pin(pg),
    .i_port_h_pull_select_pin(ph), .i_dir(dir), .o_pad_a(pa), .o_pad_b(pb), .o_pad_e(pe),
    .o_pad_g(pgo), .o_pad_h(pho), .o_register_block_base(base), .o_map_stop_in_wait(stop));
  // The small package variant shares every input; the bench checks only its select outputs, and the bound checker watches it too.
  if (1) begin : small_pkg
    pcr_pad_regs #(.SMALL_PACKAGE(1'b1)) pcr_pad_regs_i (.i_sys_clk(clk), .i_reset(rst),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(), .o_block_hit(),
      .i_port_g_pull_select_pin(pg), .i_port_h_pull_select_pin(ph), .i_dir(dir),
      .o_pad_a(), .o_pad_b(), .o_pad_e(), .o_pad_g(pgs), .o_pad_h(phs),
      .o_register_block_base(), .o_map_stop_in_wait());
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // A read notes its expected byte; the watcher below compares it a cycle later.
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= ~w;
    if (!w) expq.push_back(d);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  always @(posedge clk) begin
    if (rd_q) chk("rdata", expq.pop_front(), rdata);
    rd_q <= rd;
  end
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  initial begin
    #100us;
    n_mismatch++;
    results();
  end
  initial begin
    void'($urandom(32'hB12E));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bus(0, 16'h000C, 8'hD0);
    bus(0, 16'h000D, 8'h00);
    bus(0, 16'h0011, 8'h00);
    bus(1, 16'h000C, 8'hFF);
    bus(0, 16'h000C, 8'hD3);
    bus(1, 16'h000D, 8'hFF);
    bus(0, 16'h000D, 8'h6B);
    bus(0, 16'h000E, 8'h00);
    bus(0, 16'h020C, 8'h00);
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      dir <= 40'({$urandom, $urandom});
      bus(1, 16'h000C, v);
      bus(1, 16'h000D, ~v);
      bus(0, 16'h000C, v & 8'hD3);
      bus(0, 16'h000D, ~v & 8'h6B);
      #1;
      chk("a_pull", {8{v[0]}} & ~dir[7:0], pa.pull_en);
      chk("a_low", {7'h0, ~v[0]}, {7'h0, pa.low_drive});
      chk("b_pull", {8{v[1]}} & ~dir[15:8], pb.pull_en);
      chk("e_pull", {8{v[4]}} & ~dir[23:16] & 8'h8F, pe.pull_en);
      chk("g_pull", {8{v[6]}} & ~dir[31:24], pgo.pull_en);
      chk("h_pull", {8{v[7]}} & ~dir[39:32], pho.pull_en);
      chk("low_drv", {3'h0, ~v[6], ~v[5], ~v[3], ~v[1], ~v[0]}, {3'h0, pho.low_drive,
        pgo.low_drive, pe.low_drive, pb.low_drive, pa.low_drive});
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      pg <= k[0];
      ph <= ~k[0];
      repeat (8) @(posedge clk);
      #1;
      chk("g_up", 8'(k), {7'h0, pgo.pull_up});
      chk("h_up", 8'(1 - k), {7'h0, pho.pull_up});
      chk("g_small", 8'h01, {7'h0, pgs.pull_up});
      chk("h_small", 8'h00, {7'h0, phs.pull_up});
    end
    bus(1, 16'h0011, 8'h29);
    bus(0, 16'h2811, 8'h29);
    #1;
    chk("base", 8'h05, {3'h0, base});
    chk("stop", 8'h01, {7'h0, stop});
    chk("hit", 8'h01, {7'h0, hit});
    bus(0, 16'h0011, 8'h00);
    bus(0, 16'h2A11, 8'h00);
    bus(1, 16'h2811, 8'h00);
    bus(0, 16'h0011, 8'h00);
    repeat (3) @(posedge clk);
    results();
  end
endmodule : tb
